//--- src_pkg.sv
// Package of constants and carrier types for the system reset controller.
// Overview of operation
// - Four sources combine into one system reset.
// - All sources equal; restart from vector 0000H.
// - Pins high impedance during reset and stabilization.
// - Low external pin resets; high releases it.
// - Watchdog reset releases itself automatically.
// - Supply detector resets release above threshold.
// - Oscillators stop and external clock ignored.
// - Stop-mode state held during reset input.
package src_pkg;

  // Clock period in picoseconds (125 MHz).
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Least external reset pulse width, in microseconds.
  localparam int unsigned EXT_PULSE_MIN_US = 10;
  // Cycles that cover the least pulse, rounded up.
  localparam int unsigned EXT_PULSE_CYC =
    (EXT_PULSE_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Reset processing interval in clock cycles.
  localparam int unsigned PROC_CYC = 64;
  // Oscillation stabilization interval in clock cycles.
  localparam int unsigned STAB_CYC = 256;
  // Reset vector low and high byte addresses.
  localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR = 16'h0001;
  // Option bit codes for power-on-clear detect level.
  localparam logic DETECT_LEVEL_1V59 = 1'h0;
  localparam logic DETECT_LEVEL_2V7 = 1'h1;

  // Sequencer states.
  typedef enum logic [1:0] {
    SRC_RESET,
    SRC_PROCESS,
    SRC_STABILIZE,
    SRC_RUN
  } src_state_t;

  // Raw reset requests, each active high.
  typedef struct packed {
    logic ext_pin;
    logic watchdog;
    logic power_on_clear;
    logic low_supply;
  } src_sources_t;

  // Control outputs toward the rest of the chip.
  typedef struct packed {
    logic sys_rst_n;
    logic pins_hiz;
    logic osc_stop;
    logic ext_clk_ignore;
    logic stop_hold;
  } src_ctrl_t;

endpackage

//--- src_reset_ctrl.sv
// System reset controller: combines sources and sequences release.
module src_reset_ctrl #(
  parameter int unsigned PROC_CYCLES = src_pkg::PROC_CYC,
  parameter int unsigned STAB_CYCLES = src_pkg::STAB_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Reset sources.
  input wire logic ext_reset_n,
  input wire logic watchdog_overflow,
  input wire logic power_on_clear_detector,
  input wire logic low_supply_detector,
  // Option byte and power-mode status.
  input wire logic detect_level_option,
  input wire logic stop_mode_active,
  // Control outputs.
  output src_pkg::src_ctrl_t ctrl,
  output logic poc_mode_2v7,
  output logic [15:0] fetch_vector_addr,
  output src_pkg::src_sources_t reset_cause
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks.

  // Counters are 16 bits wide, so longer intervals cannot be served.
  // A zero count would skip a phase and break the release order.
  if (PROC_CYCLES == 0 || PROC_CYCLES > 32'h0000FFFF) begin : g_bad_proc
    $error("PROC_CYCLES out of range");
  end
  if (STAB_CYCLES == 0 || STAB_CYCLES > 32'h0000FFFF) begin : g_bad_stab
    $error("STAB_CYCLES out of range");
  end

  // Last count value of each timed phase.
  localparam logic [15:0] PROC_LAST = 16'(PROC_CYCLES - 1);
  localparam logic [15:0] STAB_LAST = 16'(STAB_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Source combination.

  // All four sources form one request; no source is treated differently.
  src_pkg::src_sources_t srcs; // Current raw requests.
  logic any_src; // Any source asserted.

  // Detector levels are high while supply is low and fall once it is good.
  // Inputs are taken as synchronous, so no synchroniser sits here.
  always_comb begin
    srcs.ext_pin = ~ext_reset_n;
    srcs.watchdog = watchdog_overflow;
    srcs.power_on_clear = power_on_clear_detector;
    srcs.low_supply = low_supply_detector;
    any_src = |srcs;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  src_pkg::src_state_t state; // Present phase.
  src_pkg::src_state_t next_state; // Phase for the next cycle.
  logic [15:0] count; // Cycles spent in present timed phase.
  logic [15:0] next_count; // Count for the next cycle.
  src_pkg::src_sources_t cause; // Sticky cause of last reset.
  src_pkg::src_sources_t next_cause; // Cause record for the next cycle.
  src_pkg::src_ctrl_t next_ctrl; // Control outputs for the next cycle.
  logic next_poc_mode; // Option mode for the next cycle.

  // Next-state logic: any request restarts the whole sequence at once.
  always_comb begin
    next_state = state;
    next_count = count + 16'h0001;
    next_cause = cause | srcs;
    unique case (state)
      src_pkg::SRC_RESET: begin
        // Hold while asserted; release is taken synchronously.
        next_count = 16'h0000;
        if (!any_src) begin
          next_state = src_pkg::SRC_PROCESS;
        end
      end
      src_pkg::SRC_PROCESS: begin
        // Fixed reset processing interval.
        if (count == PROC_LAST) begin
          next_state = src_pkg::SRC_STABILIZE;
          next_count = 16'h0000;
        end
      end
      src_pkg::SRC_STABILIZE: begin
        // Pins stay floated until the oscillator has settled.
        if (count == STAB_LAST) begin
          next_state = src_pkg::SRC_RUN;
          next_count = 16'h0000;
        end
      end
      src_pkg::SRC_RUN: begin
        // Run clears the record only on a new reset entry.
        next_count = 16'h0000;
      end
    endcase
    // A request wins over every phase, so no source is ever missed.
    if (any_src) begin
      if (state == src_pkg::SRC_RUN) begin
        next_cause = srcs; // New event replaces the old record.
      end
      next_state = src_pkg::SRC_RESET;
      next_count = 16'h0000;
    end
    // Outputs follow the next state so they come straight from flops.
    next_ctrl.sys_rst_n = (next_state == src_pkg::SRC_RUN) ||
      (next_state == src_pkg::SRC_STABILIZE);
    next_ctrl.pins_hiz = (next_state != src_pkg::SRC_RUN);
    next_ctrl.osc_stop = (next_state == src_pkg::SRC_RESET);
    next_ctrl.ext_clk_ignore = (next_state == src_pkg::SRC_RESET);
    // Stop mode contents are frozen only while the sequencer stays in the reset phase.
    next_ctrl.stop_hold = (next_state == src_pkg::SRC_RESET) &&
      (stop_mode_active || ctrl.stop_hold);
    // Option level sampled while the core is still held.
    next_poc_mode = (state == src_pkg::SRC_RESET) ?
      (detect_level_option == src_pkg::DETECT_LEVEL_2V7) :
      poc_mode_2v7;
  end

  // Registers; synchronous reset puts the block into the held phase.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Held phase: core in reset, pins floated, oscillators off.
      state <= src_pkg::SRC_RESET;
      count <= 16'h0000;
      cause <= '0;
      ctrl <= '{sys_rst_n: 1'b0, pins_hiz: 1'b1, osc_stop: 1'b1,
        ext_clk_ignore: 1'b1, stop_hold: 1'b0};
      poc_mode_2v7 <= 1'b0;
      fetch_vector_addr <= src_pkg::VEC_LO_ADDR;
      reset_cause <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
      cause <= next_cause;
      ctrl <= next_ctrl;
      poc_mode_2v7 <= next_poc_mode;
      // Every source yields the same start vector.
      fetch_vector_addr <= src_pkg::VEC_LO_ADDR;
      reset_cause <= next_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // All checks share the one clock; block reset silences them.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Any request holds the core and floats the pins on the next edge.
  AST_SRC_HOLDS: assert property (
    any_src |=> !ctrl.sys_rst_n && ctrl.pins_hiz)
    else $error("Reset not applied on source");
  // The core is freed exactly one cycle plus one processing interval after the last
  // request; the core then runs while the stabilization count is still going.
  AST_PROC_LEN: assert property (
    $rose(ctrl.sys_rst_n) |->
    $past(state, PROC_CYCLES + 1) == src_pkg::SRC_RESET &&
    $past(state, PROC_CYCLES) == src_pkg::SRC_PROCESS)
    else $error("Processing interval wrong");
  // Pins stay floated for the whole stabilization phase.
  AST_HIZ_RUN: assert property (
    ctrl.sys_rst_n && state == src_pkg::SRC_STABILIZE |-> ctrl.pins_hiz)
    else $error("Pins driven during stabilization");
  // Oscillators and the external clock path are off in reset.
  AST_OSC_STOP: assert property (
    state == src_pkg::SRC_RESET |-> ctrl.osc_stop && ctrl.ext_clk_ignore)
    else $error("Oscillator running in reset");
  // A watchdog request clears itself without outside help.
  AST_WDT_REL: assert property (
    $fell(watchdog_overflow) && !any_src |=>
    state == src_pkg::SRC_PROCESS)
    else $error("Watchdog reset did not release");
  // A low pin always lands the sequencer in the held phase.
  AST_EXT_PIN: assert property (
    !ext_reset_n |=> state == src_pkg::SRC_RESET)
    else $error("External pin ignored");
  // Either supply detector releases once its supply is good again.
  AST_SUPPLY: assert property (
    $fell(power_on_clear_detector) && !any_src |=>
    state == src_pkg::SRC_PROCESS)
    else $error("Supply reset did not release");
  AST_LVD_REL: assert property (
    $fell(low_supply_detector) && !any_src |=>
    state == src_pkg::SRC_PROCESS)
    else $error("Low supply reset did not release");
  // Stop contents freeze as soon as reset arrives in stop mode.
  AST_STOP_HOLD: assert property (
    stop_mode_active && any_src |=> ctrl.stop_hold && ctrl.pins_hiz)
    else $error("Stop state not held");
  // Once frozen they stay frozen while any request remains.
  AST_STOP_KEEP: assert property (
    ctrl.stop_hold && any_src |=> ctrl.stop_hold)
    else $error("Stop state released during reset");
  // Every reset path starts from the same vector.
  AST_VECTOR: assert property (
    fetch_vector_addr == src_pkg::VEC_LO_ADDR)
    else $error("Wrong start vector");
  // The option level is taken while the core is held.
  AST_POC_MODE: assert property (
    state == src_pkg::SRC_RESET |=> poc_mode_2v7 == $past(detect_level_option))
    else $error("Detect level not sampled");
  // In the run phase the core is free and the pins are driven.
  AST_RUN_OUT: assert property (
    state == src_pkg::SRC_RUN |-> ctrl.sys_rst_n && !ctrl.pins_hiz &&
    !ctrl.osc_stop)
    else $error("Run phase outputs wrong");

  // Main scenarios: pin pulse, watchdog pulse, full release, supply
  // drop while running, and a request that restarts the processing.
  COV_EXT: cover property (!ext_reset_n ##1 ext_reset_n);
  COV_WDT: cover property (watchdog_overflow ##1 !watchdog_overflow);
  COV_RUN: cover property (state == src_pkg::SRC_RUN);
  COV_LVD: cover property (low_supply_detector && state == src_pkg::SRC_RUN);
  COV_RESTART: cover property (state == src_pkg::SRC_PROCESS && any_src);

endmodule

//--- src_partner.sv
// Far side model: reset pin driver, supply monitors and watchdog.
module src_partner (
  // Clock.
  input wire logic clk_sys,
  // Reset requests toward the controller.
  output logic ext_reset_n,
  output logic watchdog_overflow,
  output logic power_on_clear_detector,
  output logic low_supply_detector
);
  timeunit 1ns;
  timeprecision 1ps;
  // Active-high requests in cause order {ext,wdt,poc,lvd}.
  logic [3:0] req = 4'h0;
  // Cycles the pin has been low so far.
  int held = 0;
  assign ext_reset_n = ~req[3];
  assign watchdog_overflow = req[2];
  assign power_on_clear_detector = req[1];
  assign low_supply_detector = req[0];
  ////////////////////////////////////////
  // Width counter, so a pin pulse is never cut short.
  always @(posedge clk_sys) held <= req[3] ? held + 1 : 0;
  // Raise one request just after a falling edge.
  task automatic raise(input int idx);
    @(negedge clk_sys);
    req[idx] = 1'b1;
  endtask
  // Drop a request; the pin first stays low for its least width.
  task automatic drop(input int idx);
    while (idx == 3 && held < src_pkg::EXT_PULSE_CYC) @(negedge clk_sys);
    @(negedge clk_sys);
    req[idx] = 1'b0;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the system reset controller.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PROC = 2; // Short processing count.
  localparam int unsigned STAB = 4; // Short stabilization count.
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic detect_level_option = 1'b0;
  logic stop_mode_active = 1'b0;
  logic ext_reset_n, watchdog_overflow;
  logic power_on_clear_detector, low_supply_detector;
  src_pkg::src_ctrl_t ctrl;
  logic poc_mode_2v7;
  logic [15:0] fetch_vector_addr;
  src_pkg::src_sources_t reset_cause;
  int err_total = 0;
  int check_count = 0;
  always #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  src_partner u_src_partner (.clk_sys(clk_sys), .ext_reset_n(ext_reset_n),
    .watchdog_overflow(watchdog_overflow),
    .power_on_clear_detector(power_on_clear_detector),
    .low_supply_detector(low_supply_detector));
  src_reset_ctrl #(.PROC_CYCLES(PROC), .STAB_CYCLES(STAB)) u_src_reset_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
    .watchdog_overflow(watchdog_overflow),
    .power_on_clear_detector(power_on_clear_detector),
    .low_supply_detector(low_supply_detector),
    .detect_level_option(detect_level_option),
    .stop_mode_active(stop_mode_active), .ctrl(ctrl),
    .poc_mode_2v7(poc_mode_2v7), .fetch_vector_addr(fetch_vector_addr),
    .reset_cause(reset_cause));
  ////////////////////////////////////////
  // Compare and count; four-state compare so unknowns never match.
  task automatic check(input string name, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Count falling edges until a control line reaches a level.
  task automatic wait_for(input int pins, input logic lvl, output int n);
    n = 0;
    while ((pins ? ctrl.pins_hiz : ctrl.sys_rst_n) !== lvl) begin
      @(negedge clk_sys);
      n++;
      if (n > 2000) begin
        err_total++;
        give_verdict();
      end
    end
  endtask
  // Drop a source and time the release of core and then of pins.
  task automatic time_release(input int idx);
    int n;
    u_src_partner.drop(idx);
    wait_for(0, 1'b1, n);
    check("core delay", 16'(n), 16'(PROC + 1));
    check("pins hiz", 16'(ctrl.pins_hiz), 16'h1);
    check("osc run", 16'(ctrl.osc_stop), 16'h0);
    check("stop free", 16'(ctrl.stop_hold), 16'h0);
    wait_for(1, 1'b0, n);
    check("stab delay", 16'(n), 16'(STAB));
  endtask
  // Each source alone gives the same reset; the option and stop vary.
  task automatic run_source(input int idx);
    @(negedge clk_sys);
    detect_level_option = idx[0];
    stop_mode_active = idx[1];
    u_src_partner.raise(idx);
    repeat (3) @(negedge clk_sys);
    check("sys_rst_n", 16'(ctrl.sys_rst_n), 16'h0);
    check("pins_hiz", 16'(ctrl.pins_hiz), 16'h1);
    check("osc_stop", 16'(ctrl.osc_stop), 16'h1);
    check("ext_clk", 16'(ctrl.ext_clk_ignore), 16'h1);
    check("stop_hold", 16'(ctrl.stop_hold), 16'(idx[1]));
    check("poc_mode", 16'(poc_mode_2v7), 16'(idx[0]));
    check("vector", fetch_vector_addr, src_pkg::VEC_LO_ADDR);
    check("cause", 16'(reset_cause), 16'h1 << idx);
    stop_mode_active = 1'b0;
    time_release(idx);
  endtask
  // A source during processing restarts the count and adds its cause.
  task automatic restart_mid_process();
    u_src_partner.raise(2);
    u_src_partner.drop(2);
    u_src_partner.raise(0);
    repeat (2) @(negedge clk_sys);
    check("held low", 16'(ctrl.sys_rst_n), 16'h0);
    check("cause sum", 16'(reset_cause), 16'h5);
    time_release(0);
  endtask
  ////////////////////////////////////////
  // Main sequence: block reset, first release, every source, restart.
  initial begin
    int n;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    check("start", 16'(ctrl.sys_rst_n), 16'h0);
    wait_for(1, 1'b0, n);
    for (int i = 0; i < 4; i++) run_source(i);
    restart_mid_process();
    give_verdict();
  end
endmodule
